// [logic/flash_security_and_lock_cmds.sv]
// Security register, block/sector lock and resume command logic of a serial flash.
// Assumes the main array engine, write enable and suspend decoders sit outside.
// Contract
// [RULE1] Resume taken only with a suspend flag set and write in progress clear.
// [RULE2] Resume clears suspend flags, raises write in progress within 200 ns.
// [RULE3] Resume with no suspension active changes nothing.
// [RULE4] Three 512-byte security registers, each erased and programmed separately; the code erases all unlocked ones in one command.
// [RULE5] Host sets the write enable latch before security erase or program.
// [RULE6] Security erase runs only if chip select rises right after eight bits.
// [RULE7] Erase is self-timed, write in progress held, latch cleared before end.
// [RULE8] Host sends program code, three address bytes, 1 to 512 data bytes.
// [RULE9] Program is self-timed, write in progress held, latch cleared before end.
// [RULE10] A set security lock bit blocks erase and program of that register.
// [RULE11] Read takes address and dummy on rising edges, data out on falling.
// [RULE12] Read address increments per byte and wraps to zero inside the register.
// [RULE13] Per-region locks apply only with scheme select set, else range bits.
// [RULE14] Per-region lock bits are volatile and reset to locked.
// [RULE15] Single lock with 24-bit address sets that region's lock bit.
// [RULE16] Single unlock with 24-bit address clears that region's lock bit.
// [RULE17] Lock query returns the region's lock bit as the byte's LSB.
// [RULE18] Lone global lock sets all lock bits, global unlock clears them.
// [RULE19] Register chosen by address bits 15-12, other high bits zero.
// [RULE20] With scheme select set, locked regions refuse array erase or program.
module flash_security_and_lock_cmds
  import flash_sec_pkg::*;
#(
  parameter logic [TIMER_W-1:0] SECREG_ERASE_CYCLES = 24'h001000,
  parameter logic [TIMER_W-1:0] SECREG_PROG_CYCLES = 24'h000800
) (
  // System clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Serial link pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe_n,
  // Status bits
  output logic o_write_in_progress,
  output logic o_write_enable_latch,
  output logic [1:0] o_suspend_flags,
  // Main array engine and neighbouring command decoders
  input wire logic i_write_enable_cmd,
  input wire logic i_array_start,
  input wire logic i_array_done,
  input wire logic i_suspend_req,
  input wire logic i_suspend_is_erase,
  output logic o_resume_cmd,
  // Protection configuration and query
  input wire logic [2:0] i_secreg_lock_bits,
  input wire logic i_protect_scheme_select,
  input wire logic i_range_protected,
  input wire logic [23:0] i_check_addr,
  output logic o_check_protected
);

  logic [7:0] link_rx_byte;
  logic link_rx_toggle, link_mid_byte;
  logic cs_high, rx_tgl_s, mid_s;
  logic [7:0] tx_hold, next_tx_hold;

  spi_link u_link (
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_si(i_si),
    .o_so(o_so),
    .o_so_oe_n(o_so_oe_n),
    .i_tx_byte(tx_hold),
    .o_rx_byte(link_rx_byte),
    .o_rx_toggle(link_rx_toggle),
    .o_mid_byte(link_mid_byte)
  );

  sync3 #(.INIT(1'b1)) u_sync_cs (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_d(i_cs_n),
    .o_q(cs_high)
  );

  sync3 #(.INIT(1'b0)) u_sync_tgl (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_d(link_rx_toggle),
    .o_q(rx_tgl_s)
  );

  // Only read after chip select has risen, when the serial clock is still
  sync3 #(.INIT(1'b0)) u_sync_mid (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_d(link_mid_byte),
    .o_q(mid_s)
  );

  // Storage
  logic [7:0] secreg_mem [0:1535];
  logic [7:0] prog_buf [0:511];
  logic mem_we, pbuf_we;
  logic [SECREG_IDX_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [SECREG_OFS_W-1:0] pbuf_wa;

  // Frame state
  logic last_tgl, next_last_tgl;
  logic last_cs, next_last_cs;
  logic end_pend, next_end_pend;
  logic [11:0] byte_idx, next_byte_idx;
  logic [7:0] cmd, next_cmd;
  logic [23:0] addr, next_addr;
  logic [SECREG_OFS_W-1:0] wr_ptr, next_wr_ptr;
  logic [9:0] prog_cnt, next_prog_cnt;
  logic [1:0] rd_sel, next_rd_sel;
  logic [SECREG_OFS_W-1:0] rd_ofs, next_rd_ofs;

  // Status state
  logic write_in_progress, next_wip;
  logic write_enable_latch, next_wel;
  logic [1:0] susp, next_susp;
  logic arr_active, next_arr_active;
  logic resume_pulse, next_resume_pulse;
  logic [NUM_LOCKS-1:0] lock_bits, next_lock_bits;

  // Self-timed cycle state
  cyc_e cyc_state, next_cyc_state;
  logic [10:0] cyc_cnt, next_cyc_cnt;
  logic [TIMER_W-1:0] timer, next_timer;
  logic [1:0] op_sel, next_op_sel;
  logic [SECREG_OFS_W-1:0] op_ofs, next_op_ofs;
  logic [9:0] op_len, next_op_len;

  logic byte_evt;
  logic [23:0] full_addr;
  logic [SECREG_IDX_W-1:0] prog_idx;
  logic [SECREG_OFS_W-1:0] rd_first;

  always_comb begin
    next_last_tgl = rx_tgl_s;
    next_last_cs = cs_high;
    next_end_pend = cs_high & ~last_cs;
    next_byte_idx = byte_idx;
    next_cmd = cmd;
    next_addr = addr;
    next_wr_ptr = wr_ptr;
    next_prog_cnt = prog_cnt;
    next_rd_sel = rd_sel;
    next_rd_ofs = rd_ofs;
    next_tx_hold = tx_hold;
    next_wip = write_in_progress;
    next_wel = write_enable_latch;
    next_susp = susp;
    next_arr_active = arr_active;
    next_resume_pulse = 1'b0;
    next_lock_bits = lock_bits;
    next_cyc_state = cyc_state;
    next_cyc_cnt = cyc_cnt;
    next_timer = timer;
    next_op_sel = op_sel;
    next_op_ofs = op_ofs;
    next_op_len = op_len;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = 8'h00;
    pbuf_we = 1'b0;
    pbuf_wa = wr_ptr;
    byte_evt = (rx_tgl_s != last_tgl) && !cs_high;
    full_addr = {addr[15:0], link_rx_byte};
    rd_first = full_addr[SECREG_OFS_W-1:0];
    prog_idx = {op_sel, SECREG_OFS_W'(op_ofs + cyc_cnt[SECREG_OFS_W-1:0])};

    // Bytes of the current frame
    if (byte_evt) begin
      if (byte_idx != 12'hFFF) begin
        next_byte_idx = byte_idx + 12'h001;
      end
      if (byte_idx == 12'h000) begin
        next_cmd = link_rx_byte;
      end else if (byte_idx <= IDX_ADDR_LAST) begin
        next_addr = full_addr;
      end
      if (cmd == CMD_SECREG_READ) begin
        if (byte_idx == IDX_ADDR_LAST) begin
          next_rd_sel = secreg_sel(full_addr); // [RULE19]
          next_rd_ofs = rd_first + 9'h001;
          next_tx_hold = secreg_valid(full_addr) ?
            secreg_mem[{secreg_sel(full_addr), rd_first}] : SECREG_BAD_READ;
          if (!secreg_valid(full_addr)) begin
            next_rd_sel = 2'h3;
          end
        end else if (byte_idx > IDX_ADDR_LAST) begin
          // Offset wraps inside the selected register [RULE12]
          next_rd_ofs = rd_ofs + 9'h001;
          next_tx_hold = (rd_sel == 2'h3) ? SECREG_BAD_READ : secreg_mem[{rd_sel, rd_ofs}];
        end
      end
      // The region is known after the middle address byte, in time for the reply
      if (cmd == CMD_LOCK_QUERY && byte_idx == IDX_ADDR_MID) begin
        next_tx_hold = {7'h00, lock_bits[lock_index({addr[7:0], link_rx_byte, 8'h00})]}; // [RULE17]
      end
      if (cmd == CMD_SECREG_PROG && byte_idx > IDX_ADDR_LAST) begin
        pbuf_we = 1'b1; // [RULE8]
        next_wr_ptr = wr_ptr + 9'h001;
        if (prog_cnt != SECREG_BYTES) begin
          next_prog_cnt = prog_cnt + 10'h001;
        end
      end
    end

    // Neighbouring decoders and the main array engine
    if (i_write_enable_cmd && !write_in_progress) begin
      next_wel = 1'b1;
    end
    if (i_array_start && !write_in_progress) begin
      next_wip = 1'b1;
      next_arr_active = 1'b1;
    end
    if (i_array_done && arr_active && write_in_progress) begin
      next_wip = 1'b0;
      next_arr_active = 1'b0;
    end
    if (i_suspend_req && arr_active && write_in_progress && susp == 2'b00) begin
      next_wip = 1'b0;
      next_susp = i_suspend_is_erase ? 2'b01 : 2'b10;
    end

    // Self-timed security register cycles
    if (timer != '0) begin
      next_timer = timer - 24'h000001;
    end
    unique case (cyc_state)
      CYC_IDLE: begin
      end
      CYC_ERASE: begin
        mem_wa = cyc_cnt;
        mem_wd = SECREG_ERASED;
        mem_we = !i_secreg_lock_bits[cyc_cnt[10:9]]; // [RULE10]
        next_cyc_cnt = cyc_cnt + 11'h001;
        if (cyc_cnt == SECREG_TOTAL_LAST) begin
          next_cyc_state = CYC_WAIT;
        end
      end
      CYC_PROG: begin
        // Flash programming only clears bits
        mem_wa = prog_idx;
        mem_wd = secreg_mem[prog_idx] & prog_buf[cyc_cnt[SECREG_OFS_W-1:0]];
        mem_we = 1'b1;
        next_cyc_cnt = cyc_cnt + 11'h001;
        if (cyc_cnt == {1'b0, op_len - 10'h001}) begin
          next_cyc_state = CYC_WAIT;
        end
      end
      CYC_WAIT: begin
        if (timer == '0) begin
          next_cyc_state = CYC_IDLE;
          next_wip = 1'b0; // [RULE7] [RULE9]
        end
      end
    endcase

    // Commands execute when chip select rises, whole bytes only
    if (end_pend) begin
      next_byte_idx = 12'h000;
      next_wr_ptr = '0;
      next_prog_cnt = 10'h000;
      next_tx_hold = 8'h00;
      if (!mid_s && !write_in_progress) begin
        if (cmd == CMD_RESUME && byte_idx == LEN_CMD_ONLY && susp != 2'b00) begin // [RULE1] [RULE3]
          next_susp = 2'b00; // [RULE2]
          next_wip = 1'b1;
          next_arr_active = 1'b1;
          next_resume_pulse = 1'b1;
        end
        // Erases every security register whose lock bit is clear [RULE4] [RULE6]
        if (cmd == CMD_SECREG_ERASE && byte_idx == LEN_CMD_ONLY && write_enable_latch && susp == 2'b00 &&
            i_secreg_lock_bits != 3'h7) begin // [RULE5] [RULE10]
          next_cyc_state = CYC_ERASE; // [RULE7]
          next_cyc_cnt = 11'h000;
          next_timer = SECREG_ERASE_CYCLES;
          next_wip = 1'b1;
          next_wel = 1'b0;
        end
        if (cmd == CMD_SECREG_PROG && byte_idx >= LEN_PROG_MIN && write_enable_latch && susp == 2'b00 &&
            secreg_valid(addr) && !i_secreg_lock_bits[secreg_sel(addr)]) begin // [RULE5] [RULE10] [RULE19]
          next_cyc_state = CYC_PROG; // [RULE9] [RULE4]
          next_cyc_cnt = 11'h000;
          next_timer = SECREG_PROG_CYCLES;
          next_op_sel = secreg_sel(addr);
          next_op_ofs = addr[SECREG_OFS_W-1:0];
          next_op_len = prog_cnt;
          next_wip = 1'b1;
          next_wel = 1'b0;
        end
        if (cmd == CMD_LOCK_ONE && byte_idx == LEN_CMD_ADDR) begin
          next_lock_bits[lock_index(addr)] = 1'b1; // [RULE15]
        end
        if (cmd == CMD_UNLOCK_ONE && byte_idx == LEN_CMD_ADDR) begin
          next_lock_bits[lock_index(addr)] = 1'b0; // [RULE16]
        end
        if (cmd == CMD_LOCK_ALL && byte_idx == LEN_CMD_ONLY) begin
          next_lock_bits = '1; // [RULE18]
        end
        if (cmd == CMD_UNLOCK_ALL && byte_idx == LEN_CMD_ONLY) begin
          next_lock_bits = '0; // [RULE18]
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      // Adopt the synchroniser's toggle, which reset holds at 0, the link's power-up level, so no byte is invented at power-up
      last_tgl <= rx_tgl_s;
      last_cs <= 1'b1;
      end_pend <= 1'b0;
      byte_idx <= 12'h000;
      cmd <= 8'h00;
      addr <= 24'h000000;
      wr_ptr <= '0;
      prog_cnt <= 10'h000;
      rd_sel <= 2'h0;
      rd_ofs <= '0;
      tx_hold <= 8'h00;
      write_in_progress <= 1'b0;
      write_enable_latch <= 1'b0;
      susp <= 2'b00;
      arr_active <= 1'b0;
      resume_pulse <= 1'b0;
      lock_bits <= '1; // [RULE14]
      cyc_state <= CYC_IDLE;
      cyc_cnt <= 11'h000;
      timer <= '0;
      op_sel <= 2'h0;
      op_ofs <= '0;
      op_len <= 10'h000;
    end else begin
      last_tgl <= next_last_tgl;
      last_cs <= next_last_cs;
      end_pend <= next_end_pend;
      byte_idx <= next_byte_idx;
      cmd <= next_cmd;
      addr <= next_addr;
      wr_ptr <= next_wr_ptr;
      prog_cnt <= next_prog_cnt;
      rd_sel <= next_rd_sel;
      rd_ofs <= next_rd_ofs;
      tx_hold <= next_tx_hold;
      write_in_progress <= next_wip;
      write_enable_latch <= next_wel;
      susp <= next_susp;
      arr_active <= next_arr_active;
      resume_pulse <= next_resume_pulse;
      lock_bits <= next_lock_bits;
      cyc_state <= next_cyc_state;
      cyc_cnt <= next_cyc_cnt;
      timer <= next_timer;
      op_sel <= next_op_sel;
      op_ofs <= next_op_ofs;
      op_len <= next_op_len;
    end
  end

  // Contents are nonvolatile, so reset leaves them alone
  always_ff @(posedge i_clk_sys) begin
    if (mem_we) begin
      secreg_mem[mem_wa] <= mem_wd;
    end
    if (pbuf_we) begin
      prog_buf[pbuf_wa] <= link_rx_byte;
    end
  end

  assign o_write_in_progress = write_in_progress;
  assign o_write_enable_latch = write_enable_latch;
  assign o_suspend_flags = susp;
  assign o_resume_cmd = resume_pulse;
  // Array engine refuses erase or program where this is high [RULE13] [RULE20]
  assign o_check_protected = i_protect_scheme_select ? lock_bits[lock_index(i_check_addr)] : i_range_protected;
endmodule

// [logic/flash_sec_pkg.sv]
// Shared constants for the security register and block lock command logic.
// Assumes a 24-bit flash address and serial commands of one byte.
package flash_sec_pkg;

  // Command codes
  localparam logic [7:0] CMD_RESUME = 8'h7A;
  localparam logic [7:0] CMD_SECREG_ERASE = 8'h44;
  localparam logic [7:0] CMD_SECREG_PROG = 8'h42;
  localparam logic [7:0] CMD_SECREG_READ = 8'h48;
  localparam logic [7:0] CMD_LOCK_ONE = 8'h36;
  localparam logic [7:0] CMD_UNLOCK_ONE = 8'h39;
  localparam logic [7:0] CMD_LOCK_QUERY = 8'h3D;
  localparam logic [7:0] CMD_LOCK_ALL = 8'h7E;
  localparam logic [7:0] CMD_UNLOCK_ALL = 8'h98;

  // Frame lengths in bytes and byte positions within a frame
  localparam logic [11:0] LEN_CMD_ONLY = 12'h001;
  localparam logic [11:0] LEN_CMD_ADDR = 12'h004;
  localparam logic [11:0] LEN_PROG_MIN = 12'h005;
  localparam logic [11:0] IDX_ADDR_MID = 12'h002;
  localparam logic [11:0] IDX_ADDR_LAST = 12'h003;

  // Security register layout
  localparam int SECREG_OFS_W = 9;
  localparam int SECREG_IDX_W = 11;
  localparam logic [9:0] SECREG_BYTES = 10'h200;
  localparam logic [10:0] SECREG_TOTAL_LAST = 11'h5FF;
  localparam logic [7:0] SECREG_ERASED = 8'hFF;
  localparam logic [7:0] SECREG_BAD_READ = 8'hFF;
  localparam logic [3:0] SECREG_SEL_FIRST = 4'h1;
  localparam logic [3:0] SECREG_SEL_LAST = 4'h3;

  // Block and sector lock layout: sectors in the first and last block, blocks elsewhere
  localparam int NUM_LOCKS = 286;
  localparam int LOCK_IDX_W = 9;
  localparam logic [7:0] BLOCK_FIRST = 8'h00;
  localparam logic [7:0] BLOCK_LAST = 8'hFF;
  localparam logic [8:0] LOCK_TOP_BASE = 9'h010;
  localparam logic [8:0] LOCK_MID_BASE = 9'h01F;

  // Timer width for the self-timed cycles
  localparam int TIMER_W = 24;

  typedef enum logic [1:0] {CYC_IDLE, CYC_ERASE, CYC_PROG, CYC_WAIT} cyc_e;

  function automatic logic secreg_valid(input logic [23:0] a);
    return (a[23:16] == 8'h00) && (a[11:9] == 3'h0) &&
           (a[15:12] >= SECREG_SEL_FIRST) && (a[15:12] <= SECREG_SEL_LAST);
  endfunction

  function automatic logic [1:0] secreg_sel(input logic [23:0] a);
    logic [3:0] f;
    f = a[15:12] - SECREG_SEL_FIRST;
    return f[1:0];
  endfunction

  function automatic logic [LOCK_IDX_W-1:0] lock_index(input logic [23:0] a);
    logic [7:0] blk;
    logic [3:0] sec;
    blk = a[23:16];
    sec = a[15:12];
    if (blk == BLOCK_FIRST) begin
      return {5'h00, sec};
    end else if (blk == BLOCK_LAST) begin
      return LOCK_TOP_BASE + {5'h00, sec};
    end
    return LOCK_MID_BASE + {1'b0, blk};
  endfunction

endpackage

// [logic/sync3.sv]
// Three-stage synchroniser for a single level from a foreign clock domain.
// Output follows once the second and third stages agree.
module sync3 #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Level
  input wire logic i_d,
  output logic o_q
);
  logic s1, s2, s3, q;
  logic next_q;

  always_comb begin
    next_q = q;
    if (s2 == s3) begin
      next_q = s3;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q <= INIT;
    end else begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end

  assign o_q = q;
endmodule

// [logic/spi_link.sv]
// Serial link front end on the host's serial clock (mode 0).
// Assumes chip select high clears the bit counter; serial clock idles outside frames.
module spi_link (
  // Link pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe_n,
  // Towards the system domain
  input wire logic [7:0] i_tx_byte,
  output logic [7:0] o_rx_byte,
  output logic o_rx_toggle,
  output logic o_mid_byte
);
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [6:0] shift_in, next_shift_in;
  logic [7:0] rx_byte, next_rx_byte;
  // Power-up value: the link domain has no reset, and an unknown toggle never resolves
  logic rx_toggle = 1'b0;
  logic next_rx_toggle;
  logic mid_byte, next_mid_byte;
  logic [7:0] shift_out, next_shift_out;

  always_comb begin
    next_bit_cnt = bit_cnt + 3'h1;
    next_shift_in = {shift_in[5:0], i_si};
    next_rx_byte = rx_byte;
    next_rx_toggle = rx_toggle;
    next_mid_byte = (next_bit_cnt != 3'h0);
    if (bit_cnt == 3'h7) begin
      next_rx_byte = {shift_in, i_si};
      next_rx_toggle = ~rx_toggle;
    end
  end

  // Input bits are taken on rising edges [RULE11]
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_cnt <= 3'h0;
      shift_in <= 7'h00;
    end else begin
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
    end
  end

  // Kept across chip select so the system side can judge the frame after it ends
  always_ff @(posedge i_sclk) begin
    rx_byte <= next_rx_byte;
    rx_toggle <= next_rx_toggle;
    mid_byte <= next_mid_byte;
  end

  // The transmit byte is quasi-static: the system side changes it at least
  // seven clock periods away from the byte boundary where it is loaded.
  always_comb begin
    next_shift_out = {shift_out[6:0], 1'b0};
    if (bit_cnt == 3'h0) begin
      next_shift_out = i_tx_byte;
    end
  end

  // Output bits change on falling edges [RULE11]
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      shift_out <= 8'h00;
    end else begin
      shift_out <= next_shift_out;
    end
  end

  assign o_so = shift_out[7];
  assign o_so_oe_n = i_cs_n;
  assign o_rx_byte = rx_byte;
  assign o_rx_toggle = rx_toggle;
  assign o_mid_byte = mid_byte;
endmodule

// [tb/flash_sec_sva.sv]
// Concurrent checks on the security register and lock command block.
// Assumes it is bound to the block's top module and sees only its ports.
module flash_sec_sva (
  // Clock, reset and link
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_cs_n,
  input wire logic o_so_oe_n,
  // Status and array side
  input wire logic o_write_in_progress,
  input wire logic o_write_enable_latch,
  input wire logic [1:0] o_suspend_flags,
  input wire logic i_array_start,
  input wire logic i_array_done,
  input wire logic i_suspend_req,
  input wire logic o_resume_cmd,
  // Protection
  input wire logic i_protect_scheme_select,
  input wire logic i_range_protected,
  input wire logic o_check_protected
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  // A rise of busy that neither the array nor a resume explains is a security register cycle
  sequence s_secreg_start;
    $rose(o_write_in_progress) && !$past(i_array_start) && $past(o_suspend_flags) == 2'h0;
  endsequence
  property p_resume_cause;
    o_resume_cmd |-> $past(o_suspend_flags) != 2'h0 && !$past(o_write_in_progress);
  endproperty
  a_resume_cause: assert property (p_resume_cause) else $error("resume taken without suspension");
  property p_resume_state;
    o_resume_cmd |-> o_write_in_progress && o_suspend_flags == 2'h0;
  endproperty
  a_resume_state: assert property (p_resume_state) else $error("resume did not set busy and clear flags");
  property p_flag_clear;
    $past(o_suspend_flags) != 2'h0 && o_suspend_flags == 2'h0 |-> o_resume_cmd;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("suspend flags cleared without resume");
  property p_wel_need;
    s_secreg_start |-> $past(o_write_enable_latch);
  endproperty
  a_wel_need: assert property (p_wel_need) else $error("security cycle started without write enable");
  property p_wip_hold;
    s_secreg_start |=> o_write_in_progress [*8];
  endproperty
  a_wip_hold: assert property (p_wip_hold) else $error("busy dropped early in a self-timed cycle");
  property p_wel_end;
    $fell(o_write_in_progress) && !$past(i_array_done) && !$past(i_suspend_req) |-> !o_write_enable_latch;
  endproperty
  a_wel_end: assert property (p_wel_end) else $error("write enable latch still set at cycle end");
  property p_range;
    !i_protect_scheme_select |-> o_check_protected == i_range_protected;
  endproperty
  a_range: assert property (p_range) else $error("range protection not followed");
  property p_reset_locked;
    $past(i_reset) && i_protect_scheme_select |-> o_check_protected;
  endproperty
  a_reset_locked: assert property (p_reset_locked) else $error("regions not locked after reset");
  property p_oe;
    o_so_oe_n == i_cs_n;
  endproperty
  a_oe: assert property (p_oe) else $error("output enable does not follow chip select");
endmodule

bind flash_security_and_lock_cmds flash_sec_sva u_sva (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
  .i_cs_n(i_cs_n), .o_so_oe_n(o_so_oe_n), .o_write_in_progress(o_write_in_progress),
  .o_write_enable_latch(o_write_enable_latch), .o_suspend_flags(o_suspend_flags),
  .i_array_start(i_array_start), .i_array_done(i_array_done), .i_suspend_req(i_suspend_req),
  .o_resume_cmd(o_resume_cmd), .i_protect_scheme_select(i_protect_scheme_select),
  .i_range_protected(i_range_protected), .o_check_protected(o_check_protected));

// [tb/spi_host.sv]
// Host serial controller model sending mode 0 frames.
// Assumes the device shifts read data out on falling clock edges.
module spi_host (
  // Link pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx [0:3];
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // Clock stands low between frames; 125 ns per bit
  task automatic frame(input logic [7:0] tx [0:7], input int ntx, input int nrx);
    logic [7:0] b;
    o_cs_n = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      b = (i < ntx) ? tx[i] : 8'h00;
      for (int k = 7; k >= 0; k--) begin
        o_si = b[k];
        #62;
        o_sclk = 1'b1;
        if (i >= ntx) rx[i - ntx][k] = i_so;
        #63;
        o_sclk = 1'b0;
      end
    end
    #62;
    o_cs_n = 1'b1;
    o_si = ~o_si;
    // Gap covers the chip select synchroniser and the pending cycle
    #400;
  endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the security register and lock command block.
// Assumes shortened self-timed cycles; frames come from the host model.
module tb
  import flash_sec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sise = 1'b0;
  logic protect_scheme_select = 1'b1;
  logic rng = 1'b0;
  logic [3:0] pv = 4'h0;
  logic [2:0] lockb = 3'h0;
  logic [23:0] caddr = 24'h123456;
  logic sclk, cs_n, si, so, so_oe_n, write_in_progress, write_enable_latch, rsm, prot;
  logic [1:0] flags;
  logic [7:0] t [0:7];
  logic [7:0] rd [0:2];
  int mismatches = 0;
  int cmp_count = 0;
  int rsm_cnt = 0;
  always #25 clk = ~clk;
  always @(negedge clk) if (rsm === 1'b1) rsm_cnt++;
  spi_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so));
  flash_security_and_lock_cmds #(.SECREG_ERASE_CYCLES(24'h000010), .SECREG_PROG_CYCLES(24'h000010)) DUT (
    .i_clk_sys(clk), .i_reset(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe_n(so_oe_n),
    .o_write_in_progress(write_in_progress), .o_write_enable_latch(write_enable_latch), .o_suspend_flags(flags),
    .i_write_enable_cmd(pv[0]), .i_array_start(pv[1]), .i_array_done(pv[2]), .i_suspend_req(pv[3]),
    .i_suspend_is_erase(sise), .o_resume_cmd(rsm), .i_secreg_lock_bits(lockb),
    .i_protect_scheme_select(protect_scheme_select), .i_range_protected(rng), .i_check_addr(caddr), .o_check_protected(prot));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    pv <= m;
    @(posedge clk);
    pv <= 4'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [7:0] c, input logic [23:0] a, input int ntx, input int nrx,
                      input logic [7:0] d0 = 8'h00, input logic [7:0] d1 = 8'h00);
    t = '{c, a[23:16], a[15:8], a[7:0], d0, d1, 8'h00, 8'h00};
    host.frame(t, ntx, nrx);
  endtask
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (write_in_progress !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        mismatches++;
        report_and_stop();
      end
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("flags_reset", 8'h00, {6'h00, flags});
    chk("prot_reset", 8'h01, 8'(prot));
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      protect_scheme_select <= i[1];
      rng <= i[0];
      #1;
      chk("prot_scheme", 8'(i != 0), 8'(prot));
    end
    send(CMD_UNLOCK_ALL, 24'h000000, 1, 0);
    chk("prot_unlock_all", 8'h00, 8'(prot));
    send(CMD_LOCK_ONE, 24'h120000, 4, 0);
    chk("prot_lock_one", 8'h01, 8'(prot));
    send(CMD_LOCK_QUERY, 24'h123400, 4, 1);
    chk("query_locked", 8'h01, host.rx[0]);
    send(CMD_UNLOCK_ONE, 24'h12FFFF, 4, 0);
    chk("prot_unlock_one", 8'h00, 8'(prot));
    send(CMD_LOCK_QUERY, 24'h120000, 4, 1);
    chk("query_unlocked", 8'h00, host.rx[0]);
    send(CMD_LOCK_ALL, 24'h000000, 1, 0);
    chk("prot_lock_all", 8'h01, 8'(prot));
    send(CMD_RESUME, 24'h000000, 1, 0);
    chk("resume_ignored", 8'h00, {5'h00, flags, write_in_progress} | 8'(rsm_cnt));
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      sise <= i[0];
      pulse(4'h2);
      pulse(4'h8);
      chk("suspended", {6'h00, ~i[0], i[0]}, {6'h00, flags});
      send(CMD_RESUME, 24'h000000, 1, 0);
      chk("resumed", 8'h01, {6'h00, flags} | {7'h00, write_in_progress} << 0);
      chk("resume_pulses", 8'(i + 1), 8'(rsm_cnt));
      pulse(4'h4);
    end
    @(posedge clk);
    lockb <= 3'h4;
    pulse(4'h1);
    send(CMD_SECREG_ERASE, 24'h000000, 1, 0);
    chk("erase_busy", 8'h01, {6'h00, write_enable_latch, write_in_progress});
    wait_idle(2000);
    pulse(4'h1);
    send(CMD_SECREG_PROG, 24'h0011FE, 6, 0, 8'hA5, 8'h3C);
    chk("prog_busy", 8'h01, {6'h00, write_enable_latch, write_in_progress});
    wait_idle(100);
    send(CMD_SECREG_READ, 24'h0011FE, 5, 3);
    rd = '{8'hA5, 8'h3C, SECREG_ERASED};
    for (int k = 0; k < 3; k++) chk("read_wrap", rd[k], host.rx[k]);
    send(CMD_SECREG_READ, 24'h0021FE, 5, 1);
    chk("other_register", SECREG_ERASED, host.rx[0]);
    pulse(4'h1);
    send(CMD_SECREG_PROG, 24'h003000, 5, 0, 8'h00);
    chk("locked_prog", 8'h00, 8'(write_in_progress));
    send(CMD_SECREG_ERASE, 24'h000000, 2, 0);
    chk("long_erase", 8'h00, 8'(write_in_progress));
    send(CMD_SECREG_PROG, 24'h004000, 5, 0, 8'h00);
    chk("bad_address", 8'h00, 8'(write_in_progress));
    report_and_stop();
  end
endmodule
